// ### verilog/cdm_pkg.sv
// Package: constants for the code-table load and external data move executor
package cdm_pkg;
  // Opcodes
  localparam logic [7:0] OP_CTL_PTR = 8'h93;
  localparam logic [7:0] OP_CTL_PC = 8'h83;
  localparam logic [7:0] OP_XRD_PTR = 8'he0;
  localparam logic [7:0] OP_XWR_PTR = 8'hf0;
  localparam logic [6:0] OP_XRD_IND_HI = 7'h71;
  localparam logic [6:0] OP_XWR_IND_HI = 7'h79;
  // Machine cycles per instruction
  localparam logic [1:0] INSTR_CYCLES = 2'h2;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] PORT_RST = 8'hff;
  typedef enum logic [3:0] {
    CDM_IDLE = 4'b0001,
    CDM_ADDR = 4'b0010,
    CDM_DATA = 4'b0100,
    CDM_DONE = 4'b1000
  } cdm_state_e;
endpackage

// ### verilog/cdm_exec.sv
// Execution unit for code-table loads and external data moves
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Notes on behaviour
// (RULE_01) A code-table load puts into the accumulator the code byte at accumulator plus base.
// (RULE_02) With the program counter as base, it is first advanced past the opcode, then added.
// (RULE_03) With the sixteen-bit pointer as base, the pointer is left unchanged.
// (RULE_04) The address sum is a full sixteen-bit add with carry into the high byte.
// (RULE_05) Code-table loads leave all status flags, carry and parity included, untouched.
// (RULE_06) Opcode 93h is the pointer-based code-table load, one byte, two machine cycles.
// (RULE_07) Opcode 83h is the counter-based code-table load, one byte, two machine cycles.
// (RULE_08) An external data move transfers one byte between accumulator and external memory.
// (RULE_09) The short form uses the selected indirect register as an eight-bit address on port zero.
// (RULE_10) The pointer form drives the high pointer byte on port two and the low on port zero.
// (RULE_11) The port-two register keeps its written value while port two shows the high byte.
// (RULE_12) The pointer form reaches the whole sixteen-bit space with no port setup.
// (RULE_13) In the short form port two pins keep showing the port-two register value.
// (RULE_14) Opcodes e2h/e3h read, f2h/f3h write via indirect register, e0h reads via pointer.
// ----------------------------------------------------------------------------
module cdm_exec (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] ptr_i,
  input wire logic [7:0] ind0_i,
  input wire logic [7:0] ind1_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] psw_i,
  input wire logic p2_wr_i,
  input wire logic [7:0] p2_wdata_i,
  input wire logic [7:0] code_data_i,
  input wire logic [7:0] p0_in_i,
  output logic [15:0] code_addr_o,
  output logic code_rd_o,
  output logic [7:0] p0_out_o,
  output logic p0_oe_o,
  output logic [7:0] p2_out_o,
  output logic ale_o,
  output logic xrd_o,
  output logic xwr_o,
  output logic [7:0] acc_o,
  output logic acc_we_o,
  output logic [15:0] pc_o,
  output logic pc_we_o,
  output logic [7:0] psw_o,
  output logic [7:0] p2_reg_o,
  output logic busy_o,
  output logic done_o
);
  import cdm_pkg::*;

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  function automatic logic is_known(input logic [7:0] op);
    is_known = (op == OP_CTL_PTR) || (op == OP_CTL_PC) || (op == OP_XRD_PTR) ||
               (op == OP_XWR_PTR) || (op[7:1] == OP_XRD_IND_HI) ||
               (op[7:1] == OP_XWR_IND_HI);
  endfunction

  cdm_state_e state_r;
  logic [7:0] op_r;
  logic [15:0] xaddr_r;
  logic [7:0] acc_r;
  logic [7:0] p2_reg_r;
  logic [7:0] psw_r;

  wire is_ctl = (op_r == OP_CTL_PTR) || (op_r == OP_CTL_PC);
  wire is_wr = (op_r == OP_XWR_PTR) || (op_r[7:1] == OP_XWR_IND_HI);
  wire is_ptr_x = (op_r == OP_XRD_PTR) || (op_r == OP_XWR_PTR);
  wire [15:0] pc_next = pc_i + 16'h0001; // [RULE_02]
  // Pointer is only read here, never written back
  wire [15:0] base = (opcode_i == OP_CTL_PC) ? pc_next : ptr_i; // [RULE_03]
  wire [15:0] ctl_addr = base + {8'h00, acc_i}; // [RULE_01] [RULE_04]
  wire [7:0] ind_addr = opcode_i[0] ? ind1_i : ind0_i; // [RULE_09]

  // ----------------------------------------------------------------------------
  // Sequencer: two machine cycles, ADDR then DATA, then a done pulse
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= CDM_IDLE;
      op_r <= 8'h00;
      xaddr_r <= 16'h0000;
    end else begin
      case (state_r)
        CDM_IDLE: begin
          if (start_i && is_known(opcode_i)) begin // [RULE_06] [RULE_07] [RULE_14]
            state_r <= CDM_ADDR;
            op_r <= opcode_i;
            if (opcode_i == OP_CTL_PTR || opcode_i == OP_CTL_PC) begin
              xaddr_r <= ctl_addr;
            end else if (opcode_i == OP_XRD_PTR || opcode_i == OP_XWR_PTR) begin
              xaddr_r <= ptr_i; // [RULE_12]
            end else begin
              xaddr_r <= {8'h00, ind_addr};
            end
          end
        end
        CDM_ADDR: state_r <= CDM_DATA;
        CDM_DATA: state_r <= CDM_DONE;
        CDM_DONE: state_r <= CDM_IDLE;
        default: state_r <= CDM_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Bus pins
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_addr_o <= 16'h0000;
      code_rd_o <= 1'b0;
      p0_out_o <= PORT_RST;
      p0_oe_o <= 1'b0;
      p2_out_o <= PORT_RST;
      ale_o <= 1'b0;
      xrd_o <= 1'b0;
      xwr_o <= 1'b0;
    end else begin
      code_rd_o <= 1'b0;
      ale_o <= 1'b0;
      xrd_o <= 1'b0;
      xwr_o <= 1'b0;
      p0_oe_o <= 1'b0;
      p2_out_o <= p2_reg_r; // [RULE_13]
      if (state_r == CDM_IDLE && start_i && (opcode_i == OP_CTL_PTR || opcode_i == OP_CTL_PC))
      begin
        code_addr_o <= ctl_addr;
        code_rd_o <= 1'b1;
      end
      if (state_r == CDM_ADDR && !is_ctl) begin
        ale_o <= 1'b1;
        p0_oe_o <= 1'b1;
        p0_out_o <= xaddr_r[7:0]; // [RULE_09] [RULE_10]
        if (is_ptr_x) begin
          p2_out_o <= xaddr_r[15:8]; // [RULE_10]
        end
      end
      if (state_r == CDM_DATA && !is_ctl) begin
        if (is_ptr_x) begin
          p2_out_o <= xaddr_r[15:8];
        end
        if (is_wr) begin
          xwr_o <= 1'b1;
          p0_oe_o <= 1'b1;
          p0_out_o <= acc_i; // [RULE_08]
        end else begin
          xrd_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Port-two latch: pointer accesses never write it
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p2_reg_r <= PORT_RST;
    end else if (p2_wr_i) begin
      p2_reg_r <= p2_wdata_i; // [RULE_11]
    end
  end
  assign p2_reg_o = p2_reg_r;

  // ----------------------------------------------------------------------------
  // Results to the core
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_r <= ACC_RST;
      acc_we_o <= 1'b0;
      pc_o <= PC_RST;
      pc_we_o <= 1'b0;
      psw_r <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      acc_we_o <= 1'b0;
      pc_we_o <= 1'b0;
      done_o <= 1'b0;
      busy_o <= (state_r == CDM_IDLE) ? (start_i && is_known(opcode_i)) : (state_r != CDM_DONE);
      psw_r <= psw_i; // [RULE_05]
      if (state_r == CDM_IDLE && start_i && is_known(opcode_i)) begin
        pc_o <= pc_next; // every opcode here is one byte
        pc_we_o <= 1'b1;
      end
      if (state_r == CDM_ADDR && is_ctl) begin
        acc_r <= code_data_i; // [RULE_01]
        acc_we_o <= 1'b1;
      end
      // Sampled while the read strobe stands; during the address phase
      // port zero carries our own address, not memory data
      if (state_r == CDM_DONE && !is_ctl && !is_wr) begin
        acc_r <= p0_in_i; // [RULE_08]
        acc_we_o <= 1'b1;
      end
      if (state_r == CDM_DONE) begin
        done_o <= 1'b1;
      end
    end
  end
  assign acc_o = acc_r;
  assign psw_o = psw_r;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence s_ctl_start;
    start_i && state_r == CDM_IDLE && (opcode_i == OP_CTL_PTR || opcode_i == OP_CTL_PC);
  endsequence

  AST_CTL_ADDR: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE_01]
    s_ctl_start |=> code_rd_o && code_addr_o == $past(base) + {8'h00, $past(acc_i)})
    else $error("code fetch address wrong");
  AST_PC_ADV: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE_02]
    (s_ctl_start and opcode_i == OP_CTL_PC) |=> code_addr_o == $past(pc_i) + 16'h0001 +
      {8'h00, $past(acc_i)})
    else $error("pc base not advanced");
  AST_CTL_LOAD: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE_01]
    s_ctl_start |=> ##1 acc_we_o && acc_o == $past(code_data_i))
    else $error("code byte not loaded");
  AST_TWO_CYC: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE_06]
    (start_i && state_r == CDM_IDLE && is_known(opcode_i)) |=> busy_o ##3 done_o)
    else $error("instruction length not two cycles");
  AST_PTR_HI: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE_10]
    (state_r == CDM_ADDR && is_ptr_x) |=> ale_o && p2_out_o == xaddr_r[15:8] &&
      p0_out_o == xaddr_r[7:0])
    else $error("pointer address not driven");
  AST_P2_KEEP: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE_11]
    (!p2_wr_i) |=> $stable(p2_reg_r))
    else $error("port two latch changed");
  AST_SHORT_P2: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE_13]
    (state_r == CDM_ADDR && !is_ctl && !is_ptr_x) |=> p2_out_o == $past(p2_reg_r))
    else $error("port two not latch value");
  AST_WR_DATA: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE_08]
    (state_r == CDM_DATA && is_wr) |=> xwr_o && p0_oe_o && p0_out_o == $past(acc_i))
    else $error("write data wrong");
  AST_RD_DATA: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE_08]
    (state_r == CDM_DONE && !is_ctl && !is_wr) |-> xrd_o ##1
      (acc_we_o && acc_o == $past(p0_in_i)))
    else $error("read data not taken under read strobe");
  AST_FLAGS: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE_05]
    1'b1 |=> psw_o == $past(psw_i))
    else $error("flags modified");
endmodule

// ### dv/cdm_xram_model.sv
// External data RAM and program memory model facing the executor
`timescale 1ns/1ps
module cdm_xram_model (
  input wire logic mclk_i,
  input wire logic ale_i,
  input wire logic xrd_i,
  input wire logic xwr_i,
  input wire logic [7:0] p0_i,
  input wire logic [7:0] p2_i,
  input wire logic [15:0] code_addr_i,
  output logic [7:0] p0_o,
  output logic [7:0] code_data_o
);
  logic [7:0] mem_r [0:65535];
  logic [15:0] addr_r;
  // ----------------------------------------------------------------
  // Address latch and data drive
  // ----------------------------------------------------------------
  // Released bus shows the inverse, so a sample outside the strobe cannot pass
  assign p0_o = xrd_i ? mem_r[addr_r] : ~mem_r[addr_r];
  assign code_data_o = code_addr_i[7:0] ^ code_addr_i[15:8] ^ 8'h3c;
  always @(posedge mclk_i) begin
    if (ale_i) begin
      addr_r <= {p2_i, p0_i};
    end
    if (xwr_i) begin
      mem_r[addr_r] <= p0_i;
    end
  end
endmodule

// ### dv/testbench.sv
// Self-checking bench for the code-table load and external data move executor
`timescale 1ns/1ps
module testbench;
  import cdm_pkg::*;
  logic mclk_i = 1'b0, arst_n_i = 1'b0, start_i = 1'b0, p2_wr_i = 1'b0;
  logic [7:0] opcode_i = 8'h00, ind0_i = 8'h00, ind1_i = 8'h00, acc_i = 8'h00;
  logic [7:0] psw_i = 8'h00, p2_wdata_i = 8'h00;
  logic [15:0] pc_i = 16'h0000, ptr_i = 16'h0000;
  logic [7:0] code_data_i, p0_in_i, p0_out_o, p2_out_o, acc_o, psw_o, p2_reg_o;
  logic [15:0] code_addr_o, pc_o;
  logic code_rd_o, p0_oe_o, ale_o, xrd_o, xwr_o, acc_we_o, pc_we_o, busy_o, done_o;
  logic [15:0] ca, xa, pcv;
  logic [7:0] ra, p2r;
  logic oe, seen;
  int errors = 0;
  int comparisons = 0;
  always #12.5 mclk_i = ~mclk_i;
  cdm_exec cdm_exec_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .start_i(start_i),
    .opcode_i(opcode_i), .pc_i(pc_i), .ptr_i(ptr_i), .ind0_i(ind0_i), .ind1_i(ind1_i),
    .acc_i(acc_i), .psw_i(psw_i), .p2_wr_i(p2_wr_i), .p2_wdata_i(p2_wdata_i),
    .code_data_i(code_data_i), .p0_in_i(p0_in_i), .code_addr_o(code_addr_o),
    .code_rd_o(code_rd_o), .p0_out_o(p0_out_o), .p0_oe_o(p0_oe_o), .p2_out_o(p2_out_o),
    .ale_o(ale_o), .xrd_o(xrd_o), .xwr_o(xwr_o), .acc_o(acc_o), .acc_we_o(acc_we_o),
    .pc_o(pc_o), .pc_we_o(pc_we_o), .psw_o(psw_o), .p2_reg_o(p2_reg_o), .busy_o(busy_o),
    .done_o(done_o));
  cdm_xram_model cdm_xram_model_inst (.mclk_i(mclk_i), .ale_i(ale_o), .xrd_i(xrd_o),
    .xwr_i(xwr_o), .p0_i(p0_out_o), .p2_i(p2_out_o), .code_addr_i(code_addr_o),
    .p0_o(p0_in_i), .code_data_o(code_data_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // One instruction, capturing what each strobe carries
  // ----------------------------------------------------------------
  task automatic exec(input logic [7:0] op, input logic [7:0] acc);
    @(posedge mclk_i);
    start_i <= 1'b1;
    opcode_i <= op;
    acc_i <= acc;
    psw_i <= op ^ 8'h5d;
    {ca, xa, pcv, ra, p2r, oe, seen} = '0;
    @(posedge mclk_i);
    start_i <= 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      #1;
      if (code_rd_o === 1'b1) ca = code_addr_o;
      if (pc_we_o === 1'b1) pcv = pc_o;
      if (acc_we_o === 1'b1) ra = acc_o;
      if (ale_o === 1'b1) {xa, p2r, oe} = {p2_out_o, p0_out_o, p2_reg_o, p0_oe_o};
      if (done_o === 1'b1) seen = 1'b1;
      if (i == 1) chk(psw_o, op ^ 8'h5d);
      @(posedge mclk_i);
    end
  endtask
  task automatic t_code_loads();
    ptr_i <= 16'h12f0;
    exec(OP_CTL_PTR, 8'hff);
    chk(ca, 16'h13ef);
    chk(ra, 8'h13 ^ 8'hef ^ 8'h3c);
    pc_i <= 16'h00ff;
    exec(OP_CTL_PC, 8'h01);
    chk(pcv, 16'h0100);
    chk(ca, 16'h0101);
    chk(ra, 8'h01 ^ 8'h01 ^ 8'h3c);
  endtask
  task automatic t_short_form();
    logic [7:0] ops [4];
    ops = '{{OP_XWR_IND_HI, 1'b0}, {OP_XRD_IND_HI, 1'b0}, {OP_XWR_IND_HI, 1'b1},
      {OP_XRD_IND_HI, 1'b1}};
    ind0_i <= 8'h21;
    ind1_i <= 8'h34;
    for (int k = 0; k < 4; k++) begin
      exec(ops[k], 8'ha5 + 8'(k));
      chk(xa, (k < 2) ? 16'h5a21 : 16'h5a34);
      chk({7'h00, oe}, 16'h0001);
      if (k % 2 == 1) chk(ra, 8'ha5 + 8'(k - 1));
    end
  endtask
  task automatic t_pointer_form();
    ptr_i <= 16'hbeef;
    exec(OP_XWR_PTR, 8'hc3);
    chk(xa, 16'hbeef);
    chk(p2r, 8'h5a);
    ptr_i <= 16'h0000;
    exec(OP_XWR_PTR, 8'h3c);
    ptr_i <= 16'hbeef;
    exec(OP_XRD_PTR, 8'h00);
    chk(ra, 8'hc3);
    chk(p2_reg_o, 8'h5a);
  endtask
  task automatic t_refused();
    exec(8'h00, 8'h11);
    chk({15'h0000, seen}, 16'h0000);
    chk({15'h0000, busy_o}, 16'h0000);
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    p2_wr_i <= 1'b1;
    p2_wdata_i <= 8'h5a;
    @(posedge mclk_i);
    p2_wr_i <= 1'b0;
    t_code_loads();
    t_short_form();
    t_pointer_form();
    t_refused();
    conclude();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    errors++;
    conclude();
  end
endmodule
